// >>> src/cc_regs.svh
`ifndef CC_REGS_SVH
`define CC_REGS_SVH

// Register offsets on the register port (byte addresses, one 16-bit word each)
`define CC_OFS_CORE_CONTROL 8'h00
`define CC_OFS_STATUS_WORD 8'h02
`define CC_OFS_WINDOW_PAGE 8'h04

// Field positions in core_control
`define CC_BIT_TOP 3
`define CC_BIT_WINDOW_EN 2

// Field position of priority_level_low_bits in cpu_status_word
`define CC_LOW_MSB 7
`define CC_LOW_LSB 5

// Reset values
`define CC_RST_LEVEL 4'h0
`define CC_RST_WINDOW_EN 1'h0
`define CC_RST_PAGE 8'h00
`define CC_RST_WORD 16'h0000

// Highest level that keeps the top bit at zero
`define CC_LEVEL_MAX_LOW 4'h7

// Data address bit that selects the program window
`define CC_WIN_SEL_BIT 15

// Top bit of the window offset and of the page field
`define CC_WIN_OFS_MSB 14
`define CC_PAGE_MSB 7

`endif

// >>> src/cc_pkg.sv
package cc_pkg;

  typedef logic [7:0] cc_addr_type;
  typedef logic [15:0] cc_word_type;
  typedef logic [3:0] cc_level_type;
  typedef logic [2:0] cc_low_type;
  typedef logic [7:0] cc_page_type;
  typedef logic [22:0] cc_prog_addr_type;

endpackage

// >>> src/cc_priority_level.sv
`timescale 1ns/100ps
`include "cc_regs.svh"

module cc_priority_level
  import cc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Software side
  input wire logic sw_clear_top,
  input wire logic sw_low_wr,
  input wire cc_low_type sw_low_data,
  // Processor side
  input wire logic cpu_level_wr,
  input wire cc_level_type cpu_level_in,
  // Result
  output cc_level_type level,
  output logic top_bit
);

  cc_level_type level_d;
  cc_level_type level_q;

  always_comb begin
    level_d = level_q;
    if (sw_low_wr) begin
      level_d[2:0] = sw_low_data;
    end
    // Software can only take the top bit down; a written one is dropped
    if (sw_clear_top) begin
      level_d[3] = 1'b0;
    end
    // Processor load comes last so a raise in the clear cycle is kept
    if (cpu_level_wr) begin
      level_d = cpu_level_in;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      level_q <= `CC_RST_LEVEL;
    end else begin
      level_q <= level_d;
    end
  end

  assign top_bit = (level_q > `CC_LEVEL_MAX_LOW);
  assign level = {top_bit, level_q[2:0]};

endmodule

// >>> src/cc_core_control.sv
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "cc_regs.svh"


module cc_core_control
  import cc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register port
  input wire cc_addr_type reg_addr,
  input wire cc_word_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output cc_word_type reg_rdata,
  // Processor priority level
  input wire logic cpu_level_wr,
  input wire cc_level_type cpu_level_in,
  output cc_level_type cpu_priority_level,
  output logic priority_level_top_bit,
  // Program window lookup
  input wire logic win_req,
  input wire cc_word_type win_addr,
  output logic win_valid,
  output logic win_hit,
  output cc_prog_addr_type win_prog_addr,
  // Window enable state
  output logic program_window_enable
);

  // Exact match on the byte address; odd and unmapped addresses hit nothing
  function automatic logic addr_is(input cc_addr_type a, input cc_addr_type ofs);
    addr_is = (a == ofs);
  endfunction

  // Read image of core_control: only the top bit and the window enable exist
  function automatic cc_word_type control_image(input logic top, input logic en);
    cc_word_type w;
    w = `CC_RST_WORD;
    w[`CC_BIT_TOP] = top;
    w[`CC_BIT_WINDOW_EN] = en;
    control_image = w;
  endfunction

  // Read image of the status word: the three low priority bits, rest zero
  function automatic cc_word_type status_image(input cc_low_type low);
    cc_word_type w;
    w = `CC_RST_WORD;
    w[`CC_LOW_MSB:`CC_LOW_LSB] = low;
    status_image = w;
  endfunction

  // Read image of the window page register
  function automatic cc_word_type page_image(input cc_page_type p);
    cc_word_type w;
    w = `CC_RST_WORD;
    w[`CC_PAGE_MSB:0] = p;
    page_image = w;
  endfunction

  // A data address falls in the window when its select bit is high
  function automatic logic in_window(input cc_word_type a);
    in_window = a[`CC_WIN_SEL_BIT];
  endfunction

  // Program address: the page sits above the offset inside the window
  function automatic cc_prog_addr_type window_address(
    input cc_page_type p,
    input cc_word_type a
  );
    window_address = {p, a[`CC_WIN_OFS_MSB:0]};
  endfunction

  // Register decode
  // Unmapped addresses decode to nothing: writes are lost and reads give zero
  logic wr_control;
  logic wr_status;
  logic wr_page;
  logic rd_control;
  logic rd_status;
  logic rd_page;

  assign wr_control = reg_wr && addr_is(reg_addr, `CC_OFS_CORE_CONTROL);
  assign wr_status = reg_wr && addr_is(reg_addr, `CC_OFS_STATUS_WORD);
  assign wr_page = reg_wr && addr_is(reg_addr, `CC_OFS_WINDOW_PAGE);
  assign rd_control = reg_rd && addr_is(reg_addr, `CC_OFS_CORE_CONTROL);
  assign rd_status = reg_rd && addr_is(reg_addr, `CC_OFS_STATUS_WORD);
  assign rd_page = reg_rd && addr_is(reg_addr, `CC_OFS_WINDOW_PAGE);

  // Priority level store. The processor owns the level; software may only
  // lower the top bit or rewrite the low bits through the status word.
  // A set top bit can only come from a processor load above seven.
  cc_level_type level;
  logic top_bit;
  logic sw_clear_top;

  // Only a written zero clears; a written one leaves the bit alone.
  // A processor load in the same cycle still wins inside the level store.
  assign sw_clear_top = wr_control && !reg_wdata[`CC_BIT_TOP];

  cc_priority_level u_level (
    .core_clk(core_clk),
    .nrst(nrst),
    .sw_clear_top(sw_clear_top),
    .sw_low_wr(wr_status),
    .sw_low_data(reg_wdata[`CC_LOW_MSB:`CC_LOW_LSB]),
    .cpu_level_wr(cpu_level_wr),
    .cpu_level_in(cpu_level_in),
    .level(level),
    .top_bit(top_bit)
  );

  // Outputs of the level store are plain decodes of its flip-flops
  assign cpu_priority_level = level;
  assign priority_level_top_bit = top_bit;

  // Software state: window enable and page
  logic win_en_d;
  logic win_en_q;
  cc_page_type page_d;
  cc_page_type page_q;

  // The page is kept across enable changes, so software may set it up before
  // it opens the window.
  always_comb begin
    win_en_d = win_en_q;
    page_d = page_q;
    // A core_control write touches only the enable here; the top bit goes to
    // the level store and every other position is dropped.
    if (wr_control) begin
      win_en_d = reg_wdata[`CC_BIT_WINDOW_EN];
    end
    if (wr_page) begin
      page_d = reg_wdata[`CC_PAGE_MSB:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      win_en_q <= `CC_RST_WINDOW_EN;
      page_q <= `CC_RST_PAGE;
    end else begin
      win_en_q <= win_en_d;
      page_q <= page_d;
    end
  end

  assign program_window_enable = win_en_q;

  // Read path: data stand only in the cycle after the strobe and are zero
  // otherwise, so a stale word is never taken for a fresh answer.
  cc_word_type rdata_d;
  cc_word_type rdata_q;

  always_comb begin
    rdata_d = `CC_RST_WORD;
    if (rd_control) begin
      // Unimplemented positions stay at the zero default
      rdata_d = control_image(top_bit, win_en_q);
    end else if (rd_status) begin
      rdata_d = status_image(level[2:0]);
    end else if (rd_page) begin
      rdata_d = page_image(page_q);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= `CC_RST_WORD;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Program window translation, one cycle of latency.
  // The enable is sampled in the request cycle, so a write to core_control
  // in that same cycle affects only the next lookup.
  logic valid_d;
  logic valid_q;
  logic hit_d;
  logic hit_q;
  cc_prog_addr_type prog_d;
  cc_prog_addr_type prog_q;

  // Every request is answered; a miss carries a zero address so the data
  // side can fall through to ordinary memory.
  always_comb begin
    valid_d = win_req;
    hit_d = 1'b0;
    prog_d = '0;
    if (win_req && win_en_q && in_window(win_addr)) begin
      hit_d = 1'b1;
      prog_d = window_address(page_q, win_addr);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      valid_q <= 1'b0;
      hit_q <= 1'b0;
      prog_q <= '0;
    end else begin
      valid_q <= valid_d;
      hit_q <= hit_d;
      prog_q <= prog_d;
    end
  end

  assign win_valid = valid_q;
  assign win_hit = hit_q;
  assign win_prog_addr = prog_q;

endmodule

// >>> sim/cc_core_control_monitor.sv
`timescale 1ns/100ps
module cc_core_control_monitor
  import cc_pkg::*;
(
  // Clock and reset
  input logic core_clk,
  input logic nrst,
  // Register port
  input cc_addr_type reg_addr,
  input cc_word_type reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input cc_word_type reg_rdata,
  // Level and window
  input logic cpu_level_wr,
  input cc_level_type cpu_level_in,
  input cc_level_type cpu_priority_level,
  input logic priority_level_top_bit,
  input logic win_req,
  input cc_word_type win_addr,
  input logic win_valid,
  input logic win_hit,
  input logic program_window_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic wr0;
  logic rd0;
  assign wr0 = reg_wr && reg_addr == 8'h00;
  assign rd0 = reg_rd && reg_addr == 8'h00;
  lvl_load_a: assert property (
    cpu_level_wr |=> cpu_priority_level == $past(cpu_level_in))
    else $error("level not loaded");
  top_load_a: assert property (
    cpu_level_wr |=> priority_level_top_bit == ($past(cpu_level_in) > 4'h7))
    else $error("top bit wrong after load");
  top_rise_a: assert property (
    $rose(priority_level_top_bit) |-> $past(cpu_level_wr))
    else $error("top bit set without load");
  top_clear_a: assert property (
    wr0 && !reg_wdata[3] && !cpu_level_wr |=> !priority_level_top_bit)
    else $error("top bit not cleared");
  rd_top_a: assert property (
    rd0 |=> reg_rdata[3] == $past(priority_level_top_bit))
    else $error("top bit read wrong");
  rd_unimpl_a: assert property (
    rd0 |=> reg_rdata[15:4] == 12'h000 && reg_rdata[1:0] == 2'h0)
    else $error("unimplemented bits nonzero");
  rd_enable_a: assert property (
    rd0 |=> reg_rdata[2] == $past(program_window_enable))
    else $error("enable read wrong");
  en_write_a: assert property (
    wr0 |=> program_window_enable == $past(reg_wdata[2]))
    else $error("enable not written");
  en_hold_a: assert property (
    !wr0 |=> $stable(program_window_enable))
    else $error("enable changed without write");
  win_hit_a: assert property (
    win_req |=> win_valid && win_hit == $past(program_window_enable && win_addr[15]))
    else $error("window hit wrong");
  cover property (cpu_level_wr && cpu_level_in > 4'h7);
  cover property (wr0 && priority_level_top_bit);
  cover property (win_req && program_window_enable);
endmodule
bind cc_core_control cc_core_control_monitor mon (.*);

// >>> sim/cc_core_control_tb.sv
`timescale 1ns/100ps
module cc_core_control_tb;
  import cc_pkg::*;
  logic core_clk, nrst, reg_wr, reg_rd, cpu_level_wr, win_req, top, en, win_valid, win_hit;
  cc_addr_type reg_addr;
  cc_word_type reg_wdata, reg_rdata, win_addr;
  cc_level_type cpu_level_in, lvl;
  cc_prog_addr_type win_prog_addr;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  cc_core_control DUT (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cpu_level_wr, .cpu_level_in, .cpu_priority_level(lvl), .priority_level_top_bit(top),
    .win_req, .win_addr, .win_valid, .win_hit, .win_prog_addr, .program_window_enable(en));
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(cc_addr_type a, cc_word_type d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(cc_addr_type a, cc_word_type exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic load(cc_level_type l);
    @(posedge core_clk);
    cpu_level_in <= l;
    cpu_level_wr <= 1'b1;
    @(posedge core_clk);
    cpu_level_wr <= 1'b0;
    #1;
  endtask
  task automatic look(cc_word_type a);
    @(posedge core_clk);
    win_addr <= a;
    win_req <= 1'b1;
    @(posedge core_clk);
    win_req <= 1'b0;
    #1;
  endtask
  task automatic t_reset;
    rd(8'h00, 16'h0000);
    chk({en, lvl}, 5'h00);
  endtask
  task automatic t_bits;
    wr(8'h00, 16'hFFFF);
    chk(top, 1'b0);
    rd(8'h00, 16'h0004);
  endtask
  task automatic t_level;
    for (int i = 0; i < 16; i++) begin
      load(4'(i));
      chk({top, lvl}, {1'(i > 7), 4'(i)});
      rd(8'h00, (i > 7) ? 16'h000C : 16'h0004);
    end
    // Writing a one must not disturb a set top bit
    wr(8'h00, 16'h0008);
    chk(lvl, 4'hF);
    wr(8'h00, 16'h0000);
    chk(lvl, 4'h7);
    load(4'hA);
    wr(8'h02, 16'h0020);
    chk(lvl, 4'h9);
    rd(8'h02, 16'h0020);
    // Load and software clear in one cycle: the load wins
    @(posedge core_clk);
    cpu_level_in <= 4'hC;
    cpu_level_wr <= 1'b1;
    reg_addr <= 8'h00;
    reg_wdata <= 16'h0000;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    {cpu_level_wr, reg_wr} <= 2'b00;
    #1 chk(lvl, 4'hC);
  endtask
  task automatic t_window;
    wr(8'h04, 16'h0005);
    wr(8'h00, 16'h0004);
    look(16'h8123);
    chk({win_valid, win_hit, win_prog_addr}, {2'b11, 23'h028123});
    wr(8'h00, 16'h0000);
    look(16'h8123);
    chk({win_valid, win_hit}, 2'b10);
    rd(8'h06, 16'h0000);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Whole run needs about 100 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    nrst = 1'b0;
    {reg_wr, reg_rd, cpu_level_wr, win_req} = 4'h0;
    {reg_addr, reg_wdata, cpu_level_in, win_addr} = 44'h0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_bits();
    t_level();
    t_window();
    complete_run();
  end
endmodule
